/* design/dram_ctrl_pkg.sv */
// Package: pin carrier, timing constants and command codes for the DRAM controller
package dram_ctrl_pkg;
  localparam int ADDR_W = 10;
  localparam int CLK_MHZ = 40;
  // Times in ns; counts round up for minimums, down for maxima
  localparam int ROW_ACCESS_TIME_NS = 100;
  localparam int COLUMN_TO_WRITE_DELAY_NS = 25;
  localparam int ROW_PRECHARGE_TIME_NS = 80;
  localparam int ROW_TO_COL_NS = 25;
  localparam int COL_PULSE_NS = 35;
  localparam int COL_PRECHARGE_NS = 15;
  localparam int COLUMN_SETUP_FOR_REFRESH_NS = 10;
  localparam int REFRESH_PERIOD_NS = 15600;
  localparam int POWERUP_PAUSE_NS = 200000;
  localparam int CYC_NS = 1000 / CLK_MHZ;
  localparam int ROW_ACCESS_CYC = (ROW_ACCESS_TIME_NS + CYC_NS - 1) / CYC_NS;
  localparam int CWD_CYC = (COLUMN_TO_WRITE_DELAY_NS + CYC_NS - 1) / CYC_NS;
  localparam int PRECHARGE_CYC = (ROW_PRECHARGE_TIME_NS + CYC_NS - 1) / CYC_NS;
  localparam int RCD_CYC = (ROW_TO_COL_NS + CYC_NS - 1) / CYC_NS;
  localparam int CAS_CYC = (COL_PULSE_NS + CYC_NS - 1) / CYC_NS;
  localparam int CP_CYC = (COL_PRECHARGE_NS + CYC_NS - 1) / CYC_NS;
  localparam int CSR_CYC = (COLUMN_SETUP_FOR_REFRESH_NS + CYC_NS - 1) / CYC_NS;
  localparam int REFRESH_CYC = REFRESH_PERIOD_NS / CYC_NS;
  localparam int POWERUP_CYC = (POWERUP_PAUSE_NS + CYC_NS - 1) / CYC_NS;
  localparam int WAKE_CYCLES = 8;
  localparam int ROWS = 512;
  localparam int RAS_ACTIVE_CYC = ROW_ACCESS_CYC;
  // User command codes
  typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_RMW, CMD_RWW} cmd_t;
  // User request carrier
  typedef struct packed {
    cmd_t cmd;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic wdata;
    logic last;
  } req_t;
  // DRAM pin carrier, strobes active low
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [ADDR_W-1:0] mux_address_in;
    logic data_in;
    logic test_function_in;
  } pins_t;
endpackage : dram_ctrl_pkg

/* design/dram_ctrl.sv */
// DRAM controller: init, page accesses, refresh, counter test and test mode drive
`timescale 1ns/1ps
module dram_ctrl import dram_ctrl_pkg::*; #(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int REFRESH_CYCLES = REFRESH_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // User requests
  input wire logic req_valid,
  input wire req_t req,
  output logic req_ready,
  output logic rdata_valid,
  output logic rdata,
  output logic rdata_z,
  // Mode controls
  input wire logic test_mode_en,
  input wire logic cnt_test_start,
  input wire logic hidden_ok,
  output logic init_done,
  output logic cnt_test_busy,
  output logic cnt_test_fail,
  // DRAM pins
  output pins_t pins,
  input wire logic q_in,
  input wire logic q_oe
);
  typedef enum logic [3:0] {S_PWR, S_WAKE_LO, S_WAKE_HI, S_IDLE, S_RAS, S_CAS, S_CASHI,
    S_PRE, S_CBR_SET, S_CBR_RAS, S_HID_UP} state_t;
  typedef enum logic [2:0] {T_OFF, T_INIT, T_FILL, T_UP, T_CHK, T_DN, T_CHK2} tphase_t;
  state_t st_ff, nxt_st;
  tphase_t tp_ff, nxt_tp;
  logic [17:0] tmr_ff, nxt_tmr;
  logic [13:0] ref_ff, nxt_ref;
  logic [9:0] rows_ff, nxt_rows;
  logic [3:0] wake_ff, nxt_wake;
  logic ref_due_ff, nxt_ref_due;
  logic busy_ff, nxt_busy;
  logic cbr_test_ff, nxt_cbr_test;
  logic pol_ff, nxt_pol;
  logic fail_ff, nxt_fail;
  pins_t pins_ff, nxt_pins;
  req_t cur_ff, nxt_cur;
  logic rdy_ff, nxt_rdy, rv_ff, nxt_rv, rd_ff, nxt_rd, rz_ff, nxt_rz, done_ff, nxt_done;
  logic tmr_zero;
  assign tmr_zero = (tmr_ff == '0);
  assign req_ready = rdy_ff;
  assign rdata_valid = rv_ff;
  assign rdata = rd_ff;
  assign rdata_z = rz_ff;
  assign init_done = done_ff;
  assign cnt_test_busy = busy_ff;
  assign cnt_test_fail = fail_ff;
  assign pins = pins_ff;

  // Sequencer: one state machine owns every pin so strobes never glitch between processes
  always_comb begin
    nxt_st = st_ff;
    nxt_tp = tp_ff;
    nxt_tmr = tmr_zero ? tmr_ff : 18'(tmr_ff - 18'h1);
    nxt_ref = (ref_ff == '0) ? ref_ff : 14'(ref_ff - 14'h1);
    nxt_ref_due = ref_due_ff | (ref_ff == '0);
    nxt_rows = rows_ff;
    nxt_wake = wake_ff;
    nxt_cbr_test = cbr_test_ff;
    nxt_pol = pol_ff;
    nxt_fail = fail_ff;
    nxt_pins = pins_ff;
    nxt_cur = cur_ff;
    nxt_rdy = 1'b0;
    nxt_rv = 1'b0;
    nxt_rd = rd_ff;
    nxt_rz = rz_ff;
    nxt_done = done_ff;
    if (ref_ff == '0) begin
      nxt_ref = 14'(REFRESH_CYCLES - 1);
    end
    unique case (st_ff)
      S_PWR: if (tmr_zero) begin
        nxt_st = S_WAKE_LO;
        nxt_wake = 4'(WAKE_CYCLES);
        nxt_tmr = 18'(RAS_ACTIVE_CYC - 1);
        nxt_pins.ras_n = 1'b0;
      end
      S_WAKE_LO: if (tmr_zero) begin
        nxt_pins.ras_n = 1'b1;
        nxt_wake = 4'(wake_ff - 4'h1);
        nxt_tmr = 18'(PRECHARGE_CYC - 1);
        nxt_st = S_WAKE_HI;
      end
      S_WAKE_HI: if (tmr_zero) begin
        if (wake_ff == '0) begin
          nxt_st = S_IDLE;
          nxt_done = 1'b1;
        end else begin
          nxt_pins.ras_n = 1'b0;
          nxt_tmr = 18'(RAS_ACTIVE_CYC - 1);
          nxt_st = S_WAKE_LO;
        end
      end
      S_IDLE: begin
        nxt_pins.test_function_in = test_mode_en;
        if (req_valid && rdy_ff) begin
          // Ready was promised last cycle, so a due refresh waits for this access
          nxt_cur = req;
          nxt_pins.mux_address_in = req.row;
          nxt_pins.ras_n = 1'b0;
          nxt_tmr = 18'(RCD_CYC - 1);
          nxt_st = S_RAS;
        end else if ((ref_due_ff && tp_ff == T_OFF) || tp_ff == T_INIT) begin
          // Counter refresh: column strobe first, then row strobe; a new due pulse still wins
          nxt_ref_due = (ref_ff == '0);
          nxt_pins.cas_n = 1'b0;
          nxt_pins.we_n = 1'b1;
          nxt_cbr_test = 1'b0;
          nxt_tmr = 18'(CSR_CYC - 1);
          nxt_st = S_CBR_SET;
        end else if (tp_ff == T_UP || tp_ff == T_DN) begin
          // Counter test read-write: counter row, fixed column
          // Each test cycle refreshes a row; a plain counter refresh here would skip one
          nxt_ref_due = (ref_ff == '0);
          nxt_pins.mux_address_in = '0;
          nxt_pins.cas_n = 1'b0;
          nxt_pins.we_n = 1'b1;
          nxt_cbr_test = 1'b1;
          nxt_tmr = 18'(CSR_CYC - 1);
          nxt_st = S_CBR_SET;
        end else if (tp_ff == T_FILL || tp_ff == T_CHK || tp_ff == T_CHK2) begin
          // Normal row access on column zero; the sweep refreshes rows in turn
          nxt_ref_due = (ref_ff == '0);
          nxt_cur.cmd = (tp_ff == T_FILL) ? CMD_WRITE : CMD_READ;
          nxt_cur.row = {1'b0, rows_ff[8:0]};
          nxt_cur.col = '0;
          nxt_cur.wdata = pol_ff;
          nxt_cur.last = 1'b1;
          nxt_pins.mux_address_in = {1'b0, rows_ff[8:0]};
          nxt_pins.ras_n = 1'b0;
          nxt_tmr = 18'(RCD_CYC - 1);
          nxt_st = S_RAS;
        end else if (cnt_test_start && tp_ff == T_OFF) begin
          nxt_tp = T_INIT;
          nxt_rows = 10'(WAKE_CYCLES);
          nxt_pol = 1'b0;
          nxt_fail = 1'b0;
        end else begin
          nxt_rdy = 1'b1;
        end
      end
      S_RAS: if (tmr_zero) begin
        nxt_pins.mux_address_in = cur_ff.col;
        if (test_mode_en) nxt_pins.mux_address_in[ADDR_W-1] = 1'b0;
        nxt_pins.data_in = cur_ff.wdata;
        // Early write only for plain writes; others hold write strobe high
        nxt_pins.we_n = (cur_ff.cmd != CMD_WRITE);
        nxt_pins.cas_n = 1'b0;
        nxt_tmr = (cur_ff.cmd == CMD_RMW) ? 18'(ROW_ACCESS_CYC - RCD_CYC) :
          (cur_ff.cmd == CMD_RWW) ? 18'(CWD_CYC) : 18'(CAS_CYC - 1);
        nxt_st = S_CAS;
      end
      S_CAS: if (tmr_zero) begin
        if (pins_ff.we_n && cur_ff.cmd != CMD_READ) begin
          // Late write strobe after read data or column-to-write delay
          nxt_pins.we_n = 1'b0;
          nxt_rv = 1'b1;
          nxt_rd = q_in;
          nxt_rz = ~q_oe;
          nxt_tmr = 18'(CAS_CYC - 1);
        end else begin
          if (cur_ff.cmd == CMD_READ) begin
            nxt_rv = 1'b1;
            nxt_rd = q_in;
            nxt_rz = ~q_oe;
            if (tp_ff == T_CHK || tp_ff == T_CHK2) nxt_fail = fail_ff | ~q_oe | (q_in != pol_ff);
          end
          if (hidden_ok && cur_ff.cmd == CMD_READ && cur_ff.last && tp_ff == T_OFF) begin
            // Hidden refresh keeps read data on the output
            nxt_pins.ras_n = 1'b1;
            nxt_ref_due = (ref_ff == '0);
            nxt_tmr = 18'(PRECHARGE_CYC - 1);
            nxt_st = S_HID_UP;
          end else begin
            nxt_pins.cas_n = 1'b1;
            nxt_pins.we_n = 1'b1;
            nxt_tmr = 18'(CP_CYC - 1);
            nxt_st = S_CASHI;
          end
        end
      end
      S_CASHI: if (tmr_zero) begin
        if (!cur_ff.last && req_valid && req.row == cur_ff.row && tp_ff == T_OFF) begin
          // Next column of the open page, any access kind
          nxt_cur = req;
          nxt_rdy = 1'b1;
          nxt_tmr = '0;
          nxt_st = S_RAS;
        end else begin
          nxt_pins.ras_n = 1'b1;
          nxt_tmr = 18'(PRECHARGE_CYC - 1);
          nxt_st = S_PRE;
        end
      end
      S_HID_UP: if (tmr_zero) begin
        nxt_pins.ras_n = 1'b0;
        nxt_cbr_test = 1'b0;
        nxt_tmr = 18'(RAS_ACTIVE_CYC - 1);
        nxt_st = S_CBR_RAS;
      end
      S_CBR_SET: if (tmr_zero) begin
        nxt_pins.ras_n = 1'b0;
        nxt_tmr = 18'(RAS_ACTIVE_CYC - 1);
        nxt_st = S_CBR_RAS;
      end
      S_CBR_RAS: if (tmr_zero) begin
        if (cbr_test_ff && pins_ff.we_n) begin
          nxt_pins.data_in = (tp_ff == T_UP) ? ~pol_ff : pol_ff;
          nxt_pins.we_n = 1'b0;
          nxt_tmr = 18'(CAS_CYC - 1);
        end else begin
          nxt_pins.ras_n = 1'b1;
          nxt_pins.cas_n = 1'b1;
          nxt_pins.we_n = 1'b1;
          nxt_tmr = 18'(PRECHARGE_CYC - 1);
          nxt_st = S_PRE;
        end
      end
      S_PRE: if (tmr_zero) begin
        nxt_st = S_IDLE;
        if (tp_ff != T_OFF) begin
          // Counter test phase bookkeeping, 8 rows for the init pass, 512 rows per pass after it
          nxt_rows = 10'(rows_ff - 10'h1);
          if (rows_ff == 10'h1) begin
            nxt_rows = 10'(ROWS);
            unique case (tp_ff)
              T_INIT: nxt_tp = T_FILL;
              T_FILL: nxt_tp = T_UP;
              T_UP: begin
                nxt_tp = T_CHK;
                nxt_pol = ~pol_ff;
              end
              T_CHK: begin
                nxt_tp = T_DN;
                nxt_pol = ~pol_ff;
              end
              T_DN: nxt_tp = T_CHK2;
              T_CHK2: begin
                nxt_tp = pol_ff ? T_OFF : T_FILL;
                nxt_pol = ~pol_ff;
              end
              default: nxt_tp = T_OFF;
            endcase
          end
        end
      end
      default: nxt_st = S_IDLE;
    endcase
    // Busy flag registered so the output comes straight from a flop
    nxt_busy = (nxt_tp != T_OFF);
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= S_PWR;
      tp_ff <= T_OFF;
      tmr_ff <= 18'(POWERUP_CYCLES - 1);
      ref_ff <= 14'(REFRESH_CYCLES - 1);
      ref_due_ff <= 1'b0;
      rows_ff <= '0;
      wake_ff <= '0;
      busy_ff <= 1'b0;
      cbr_test_ff <= 1'b0;
      pol_ff <= 1'b0;
      fail_ff <= 1'b0;
      pins_ff <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, mux_address_in: '0, data_in: 1'b0,
        test_function_in: 1'b0};
      cur_ff <= '0;
      rdy_ff <= 1'b0;
      rv_ff <= 1'b0;
      rd_ff <= 1'b0;
      rz_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      tp_ff <= nxt_tp;
      tmr_ff <= nxt_tmr;
      ref_ff <= nxt_ref;
      ref_due_ff <= nxt_ref_due;
      rows_ff <= nxt_rows;
      wake_ff <= nxt_wake;
      busy_ff <= nxt_busy;
      cbr_test_ff <= nxt_cbr_test;
      pol_ff <= nxt_pol;
      fail_ff <= nxt_fail;
      pins_ff <= nxt_pins;
      cur_ff <= nxt_cur;
      rdy_ff <= nxt_rdy;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rz_ff <= nxt_rz;
      done_ff <= nxt_done;
    end
  end

  // Checks on pin sequencing
  ras_only_a: assert property (@(posedge clk) disable iff (rst)
    (st_ff == S_WAKE_LO) |-> pins.cas_n) else $error("column strobe low in wake cycle");
  cbr_order_a: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.ras_n) && st_ff == S_CBR_RAS |-> $past(!pins.cas_n)) else $error("row before column");
  read_we_a: assert property (@(posedge clk) disable iff (rst)
    (st_ff == S_CAS && cur_ff.cmd == CMD_READ) |-> pins.we_n) else $error("write strobe in read");
  rmw_late_a: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.we_n) && cur_ff.cmd == CMD_RMW |-> $past(!pins.cas_n, 2)) else $error("early rmw write");
  page_ras_a: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.cas_n) && st_ff == S_CAS |-> !pins.ras_n) else $error("column without row");
  hidden_a: assert property (@(posedge clk) disable iff (rst)
    (st_ff == S_HID_UP) |-> !pins.cas_n && pins.ras_n) else $error("hidden refresh dropped column");
  init_a: assert property (@(posedge clk) disable iff (rst)
    !init_done |-> !(st_ff == S_RAS)) else $error("access before init");
  test_msb_a: assert property (@(posedge clk) disable iff (rst)
    (st_ff == S_CAS && test_mode_en && $fell(pins.cas_n)) |-> !pins.mux_address_in[ADDR_W-1])
    else $error("msb driven in test mode");
  read_cov: cover property (@(posedge clk) st_ff == S_CAS && cur_ff.cmd == CMD_READ);
  hid_cov: cover property (@(posedge clk) st_ff == S_HID_UP);
  test_cov: cover property (@(posedge clk) tp_ff == T_CHK2);
endmodule : dram_ctrl

/* dv/dram_model.sv */
// Behavioural model of the multiplexed-address DRAM device
`timescale 1ns/1ps
module dram_model import dram_ctrl_pkg::*; (
  // Pins from the controller
  input wire pins_t pins,
  // Makes test-mode sectors disagree
  input wire logic sector_fault,
  // Device data output
  output logic q_in,
  output logic q_oe
);
  bit mem [int];
  logic [ADDR_W-1:0] row, col;
  logic [8:0] rcnt;
  logic tm, rd;
  int ras_falls, cbr_cycles;
  time first_ras;

  // Any cycle mode works within one page, so cells are keyed by row and column only
  function automatic logic fetch();
    return mem.exists({row, col}) ? mem[{row, col}] : 1'b0;
  endfunction : fetch

  initial begin
    q_in = 1'b0;
    q_oe = 1'b0;
    rcnt = '0;
    tm = 1'b0;
    ras_falls = 0;
    cbr_cycles = 0;
    first_ras = 0;
  end

  // Row strobe fall: counter refresh if column strobe already low, else row latch
  always @(negedge pins.ras_n) begin
    ras_falls++;
    if (ras_falls == 1) first_ras = $time;
    tm = pins.test_function_in;
    if (!pins.cas_n) begin
      row = {1'b0, rcnt};
      col = pins.mux_address_in;
      rcnt++;
      cbr_cycles++;
    end else begin
      row = pins.mux_address_in;
    end
  end

  // Column strobe fall in a row cycle: early write keeps output off, else read
  always @(negedge pins.cas_n) begin
    if (!pins.ras_n) begin
      col = pins.mux_address_in;
      if (tm) col[ADDR_W-1] = 1'b0;
      if (!pins.we_n) begin
        mem[{row, col}] = pins.data_in;
      end else begin
        rd = fetch();
        #5;
        q_in = rd;
        q_oe = !(tm && sector_fault);
      end
    end
  end

  // Late write for read-modify-write and read-while-write
  always @(negedge pins.we_n) begin
    if (!pins.ras_n && !pins.cas_n) mem[{row, col}] = pins.data_in;
  end

  // Output held until column strobe rises, then released with a stale-looking level
  always @(posedge pins.cas_n) begin
    if (q_oe) begin
      q_oe = 1'b0;
      q_in = ~q_in;
    end
  end
endmodule : dram_model

/* dv/dram_ctrl_tb.sv */
// Self-checking bench for the DRAM controller against the device model
`timescale 1ns/1ps
module dram_ctrl_tb import dram_ctrl_pkg::*; ;
  localparam int PWR = 20;
  localparam int RFC = 60;
  localparam int LIMIT = 95000;
  logic clk, rst, req_valid, test_mode_en, cnt_test_start, hidden_ok, sector_fault;
  logic req_ready, rdata_valid, rdata, rdata_z, init_done, cnt_test_busy, cnt_test_fail, q_in, q_oe;
  req_t req;
  pins_t pins;
  int mismatches, checks, cyc, base;

  dram_ctrl #(.POWERUP_CYCLES(PWR), .REFRESH_CYCLES(RFC)) u_dut (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rdata_valid(rdata_valid), .rdata(rdata), .rdata_z(rdata_z),
    .test_mode_en(test_mode_en), .cnt_test_start(cnt_test_start), .hidden_ok(hidden_ok), .init_done(init_done),
    .cnt_test_busy(cnt_test_busy), .cnt_test_fail(cnt_test_fail), .pins(pins), .q_in(q_in), .q_oe(q_oe));
  dram_model u_dev (.pins(pins), .sector_fault(sector_fault), .q_in(q_in), .q_oe(q_oe));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic chk_bit(string what, logic exp, logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_min(string what, int lo, int got);
    checks++;
    if (got < lo) begin
      mismatches++;
      $display("wrong value %s expected at least %0d seen %0d", what, lo, got);
    end
  endtask : chk_min

  // Bounded wait on the negedge for a level; a stuck design counts as a mismatch
  task automatic wait_for(ref logic sig, input logic lvl, input int lim, input string what);
    int n;
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk_bit(what, lvl, sig);
  endtask : wait_for

  // One request; reads are judged against the expected bit and compare flag
  task automatic access(cmd_t c, logic [9:0] r, logic [9:0] cl, logic wd, logic lst, logic exp, logic exp_z);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{cmd: c, row: r, col: cl, wdata: wd, last: lst};
    wait_for(req_ready, 1'b1, 400, "request taken");
    @(negedge clk);
    req_valid = 1'b0;
    if (c != CMD_WRITE) begin
      wait_for(rdata_valid, 1'b1, 200, "read answer");
      chk_bit("read flag", exp_z, rdata_z);
      if (!exp_z) chk_bit("read bit", exp, rdata);
    end
  endtask : access

  task automatic t_init();
    chk_bit("ready during init", 1'b0, req_ready);
    wait_for(init_done, 1'b1, 2000, "init done");
    chk_min("wake cycles", 8, u_dev.ras_falls);
    chk_min("pause ns", (PWR + 7) * 25, int'(u_dev.first_ras));
  endtask : t_init

  // Write then read, and a swapped row and column must not alias
  task automatic t_rw();
    access(CMD_WRITE, 10'h0a5, 10'h35a, 1'b1, 1'b1, 1'b0, 1'b0);
    access(CMD_READ, 10'h0a5, 10'h35a, 1'b0, 1'b1, 1'b1, 1'b0);
    access(CMD_READ, 10'h35a, 10'h0a5, 1'b0, 1'b1, 1'b0, 1'b0);
  endtask : t_rw

  // Late writes return the old bit and store the new one
  task automatic t_late();
    access(CMD_RMW, 10'h0a5, 10'h35a, 1'b0, 1'b1, 1'b1, 1'b0);
    access(CMD_READ, 10'h0a5, 10'h35a, 1'b0, 1'b1, 1'b0, 1'b0);
    access(CMD_RWW, 10'h0a5, 10'h35a, 1'b1, 1'b1, 1'b0, 1'b0);
    access(CMD_READ, 10'h0a5, 10'h35a, 1'b0, 1'b1, 1'b1, 1'b0);
  endtask : t_late

  // Mixed page on one open row
  task automatic t_page();
    access(CMD_WRITE, 10'h033, 10'h001, 1'b1, 1'b0, 1'b0, 1'b0);
    access(CMD_RMW, 10'h033, 10'h002, 1'b1, 1'b0, 1'b0, 1'b0);
    access(CMD_READ, 10'h033, 10'h001, 1'b0, 1'b0, 1'b1, 1'b0);
    access(CMD_READ, 10'h033, 10'h002, 1'b0, 1'b1, 1'b1, 1'b0);
  endtask : t_page

  task automatic t_refresh();
    base = u_dev.ras_falls;
    repeat (5 * RFC) @(negedge clk);
    chk_min("refresh cycles", base + 4, u_dev.ras_falls);
    // Closing read without hidden refresh takes the plain precharge path
    hidden_ok = 1'b0;
    access(CMD_READ, 10'h0a5, 10'h35a, 1'b0, 1'b1, 1'b1, 1'b0);
    hidden_ok = 1'b1;
  endtask : t_refresh

  // Parallel test mode: column msb ignored, disagreeing sectors give high impedance
  task automatic t_tmode();
    test_mode_en = 1'b1;
    access(CMD_WRITE, 10'h044, 10'h201, 1'b1, 1'b1, 1'b0, 1'b0);
    chk_bit("test pin", 1'b1, pins.test_function_in);
    access(CMD_READ, 10'h044, 10'h001, 1'b0, 1'b1, 1'b1, 1'b0);
    sector_fault = 1'b1;
    access(CMD_READ, 10'h044, 10'h001, 1'b0, 1'b1, 1'b0, 1'b1);
    sector_fault = 1'b0;
    test_mode_en = 1'b0;
    // Hidden refresh after the read keeps the sequencer out of idle for a while
    repeat (20) @(negedge clk);
    chk_bit("test pin off", 1'b0, pins.test_function_in);
  endtask : t_tmode

  task automatic t_cnt();
    base = u_dev.cbr_cycles;
    @(negedge clk);
    cnt_test_start = 1'b1;
    wait_for(cnt_test_busy, 1'b1, 400, "counter test busy");
    cnt_test_start = 1'b0;
    wait_for(cnt_test_busy, 1'b0, 90000, "counter test done");
    chk_bit("counter test fail", 1'b0, cnt_test_fail);
    chk_min("counter cycles", base + 8 + 2048, u_dev.cbr_cycles);
  endtask : t_cnt

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    test_mode_en = 1'b0;
    cnt_test_start = 1'b0;
    hidden_ok = 1'b1;
    sector_fault = 1'b0;
    mismatches = 0;
    checks = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_init();
    t_rw();
    t_late();
    t_page();
    t_refresh();
    t_tmode();
    t_cnt();
    tally_and_finish();
  end
endmodule : dram_ctrl_tb
